// *** pkg/eeprom_rd_pkg.sv ***
// Constants for the two-wire EEPROM half-select and read slave
package eeprom_rd_pkg;
	localparam int MEM_BYTES = 512;
	localparam int HALF_BYTES = 256;
	localparam int ADDR_W = 8;
	localparam logic [3:0] DEV_TYPE_CODE = 4'h000A;
	localparam logic [7:0] CMD_HALF_LOWER = 8'h006C;
	localparam logic [7:0] CMD_HALF_UPPER = 8'h006E;
	localparam logic [7:0] CMD_HALF_QUERY = 8'h006D;
	localparam logic [7:0] ADDR_WRAP_LAST = 8'h00FF;
	localparam logic [7:0] ADDR_WRAP_FIRST = 8'h0000;
	localparam logic HALF_RESET = 1'b0;
	localparam int DATA_FIFO_DEPTH = 8;
	localparam int DATA_W = 8;
	localparam logic [3:0] BIT_LAST = 4'h0007;
	localparam logic [3:0] BIT_ACK = 4'h0008;
endpackage : eeprom_rd_pkg

// *** verilog/pin_sync.sv ***
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// Level in and out
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = async_i;
		sync_d = meta_q;
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_q <= '1;
			sync_q <= '1;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_o = sync_q;
endmodule : pin_sync
`default_nettype wire

// *** verilog/byte_fifo.sv ***
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic flush_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [PW:0] cnt_q, cnt_d;
	logic push, pop;

	always_comb begin
		push = in_valid_i && in_ready_o;
		pop = out_valid_o && out_ready_i;
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (flush_i) begin
			wr_d = '0;
			rd_d = '0;
			cnt_d = '0;
		end else begin
			if (push) begin
				wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (push && !flush_i) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	assign in_ready_o = (cnt_q != (PW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem_q[rd_q];
endmodule : byte_fifo
`default_nettype wire

// *** verilog/eeprom_half_select_and_read.sv ***
// Two-wire EEPROM slave: half select, half query and read transactions
// Notes on behaviour
// - 512 bytes: two halves of 256 bytes each
// - Half bit picks lower or upper 256
// - 6Ch/6Eh after Start selects half, acked
// - Two dont-care bytes after select acked
// - 6Dh query: ACK lower, NACK upper
// - Two dont-care bytes out after query
// - Half bit cleared at reset and bus reset
// - Read needs 1010, strap match, R bit
// - Current read sends byte at counter
// - Counter kept between transactions
// - Counter wraps inside the selected half
// - Random read: dummy write then restart
// - Read after dummy write starts preloaded address
// - Sequential bytes while master acks
`timescale 1ns/10ps
`default_nettype none
module eeprom_half_select_and_read
	import eeprom_rd_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// Two-wire bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	// Address straps
	input wire logic strap_addr_bit0_i,
	input wire logic strap_addr_bit1_i,
	input wire logic strap_addr_bit2_i,
	// Bus software reset request
	input wire logic bus_sw_reset_i,
	// Memory load port
	input wire logic mem_we_i,
	input wire logic [8:0] mem_waddr_i,
	input wire logic [7:0] mem_wdata_i,
	// Status
	output logic half_sel_o,
	output logic busy_o
);
	import eeprom_rd_pkg::*;

	typedef enum logic [6:0] {
		ST_IDLE = 7'b000_0001,
		ST_CTRL = 7'b000_0010,
		ST_ACK = 7'b000_0100,
		ST_WADDR = 7'b000_1000,
		ST_DUMMY = 7'b001_0000,
		ST_TX = 7'b010_0000,
		ST_MACK = 7'b100_0000
	} state_t;

	typedef enum logic [2:0] {
		K_NONE = 3'b001,
		K_READ = 3'b010,
		K_CMD = 3'b100
	} kind_t;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [5:0] pins_s;
	logic scl_s, sda_s;
	logic [2:0] strap_s;
	logic bus_rst_s;

	pin_sync #(.W(6)) u_sync (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.async_i({scl_i, sda_i, strap_addr_bit2_i, strap_addr_bit1_i, strap_addr_bit0_i,
			bus_sw_reset_i}),
		.sync_o(pins_s)
	);

	assign scl_s = pins_s[5];
	assign sda_s = pins_s[4];
	assign strap_s = pins_s[3:1];
	assign bus_rst_s = pins_s[0];

	logic scl_prev_q, sda_prev_q;
	logic scl_rise, scl_fall, start_cond, stop_cond;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	always_comb begin
		scl_rise = scl_s && !scl_prev_q;
		scl_fall = !scl_s && scl_prev_q;
		start_cond = scl_s && scl_prev_q && sda_prev_q && !sda_s;
		stop_cond = scl_s && scl_prev_q && !sda_prev_q && sda_s;
	end

	// ------------------------------------------------------------
	// Memory array, 512 bytes
	// ------------------------------------------------------------
	logic [7:0] mem_q [MEM_BYTES];

	always_ff @(posedge clk_sys_i) begin
		if (mem_we_i) begin
			mem_q[mem_waddr_i] <= mem_wdata_i;
		end
	end

	function automatic logic [7:0] next_addr(input logic [7:0] a);
		// Wraps within the half; the half bit is untouched
		next_addr = (a == ADDR_WRAP_LAST) ? ADDR_WRAP_FIRST : a + 8'h0001;
	endfunction : next_addr

	// ------------------------------------------------------------
	// Protocol engine
	// ------------------------------------------------------------
	state_t st_q, st_d;
	kind_t kind_q, kind_d;
	logic [7:0] sh_q, sh_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] addr_q, addr_d;
	logic half_q, half_d;
	logic ack_q, ack_d;
	logic q_cmd_q, q_cmd_d;
	logic [1:0] dc_q, dc_d;
	logic sda_oe_n_q, sda_oe_n_d;
	logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop, fifo_flush;
	logic [7:0] fifo_out_data;

	byte_fifo #(.WIDTH(DATA_W), .DEPTH(DATA_FIFO_DEPTH)) u_fifo (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.flush_i(fifo_flush),
		.in_valid_i(fifo_in_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(mem_q[{half_q, addr_q}]),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_out_data)
	);

	logic [7:0] ctrl_byte;
	logic dev_match;

	always_comb begin
		ctrl_byte = {sh_q[6:0], sda_s};
		dev_match = (ctrl_byte[7:4] == DEV_TYPE_CODE) && (ctrl_byte[3:1] == strap_s);
		st_d = st_q;
		kind_d = kind_q;
		sh_d = sh_q;
		bit_d = bit_q;
		addr_d = addr_q;
		half_d = half_q;
		ack_d = ack_q;
		q_cmd_d = q_cmd_q;
		dc_d = dc_q;
		sda_oe_n_d = sda_oe_n_q;
		fifo_in_valid = 1'b0;
		fifo_pop = 1'b0;
		fifo_flush = 1'b0;
		if (bus_rst_s) begin
			half_d = HALF_RESET;
			st_d = ST_IDLE;
			sda_oe_n_d = 1'b1;
		end else if (stop_cond) begin
			st_d = ST_IDLE;
			sda_oe_n_d = 1'b1;
			fifo_flush = 1'b1;
		end else if (start_cond) begin
			st_d = ST_CTRL;
			bit_d = '0;
			sda_oe_n_d = 1'b1;
			fifo_flush = 1'b1;
		end else begin
			unique case (st_q)
				ST_IDLE: begin
					sda_oe_n_d = 1'b1;
				end
				ST_CTRL, ST_WADDR, ST_DUMMY: begin
					if (scl_rise) begin
						sh_d = ctrl_byte;
						bit_d = bit_q + 4'h0001;
						if (bit_q == BIT_LAST) begin
							ack_d = 1'b0;
							if (st_q == ST_CTRL) begin
								kind_d = K_NONE;
								if (ctrl_byte == CMD_HALF_LOWER || ctrl_byte == CMD_HALF_UPPER) begin
									half_d = ctrl_byte[1];
									kind_d = K_CMD;
									q_cmd_d = 1'b0;
									dc_d = 2'h2;
									ack_d = 1'b1;
								end else if (ctrl_byte == CMD_HALF_QUERY) begin
									kind_d = K_CMD;
									q_cmd_d = 1'b1;
									dc_d = 2'h2;
									ack_d = !half_q;
								end else if (dev_match) begin
									kind_d = ctrl_byte[0] ? K_READ : K_CMD;
									q_cmd_d = 1'b0;
									dc_d = ctrl_byte[0] ? 2'h0 : 2'h3;
									ack_d = 1'b1;
								end
							end else if (st_q == ST_WADDR) begin
								addr_d = ctrl_byte;
								ack_d = 1'b1;
							end else begin
								ack_d = 1'b1;
								dc_d = dc_q - 2'h1;
							end
						end
					end else if (scl_fall && bit_q == BIT_ACK) begin
						sda_oe_n_d = !ack_q;
						st_d = ST_ACK;
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						bit_d = '0;
						sda_oe_n_d = 1'b1;
						if (kind_q == K_NONE) begin
							st_d = ST_IDLE;
						end else if (kind_q == K_READ || q_cmd_q) begin
							st_d = ST_TX;
							sh_d = q_cmd_q ? 8'h00FF : fifo_out_data;
							fifo_pop = !q_cmd_q;
							if (q_cmd_q) begin
								sda_oe_n_d = 1'b1;
							end else begin
								sda_oe_n_d = fifo_out_data[7];
							end
						end else if (dc_q == 2'h3) begin
							st_d = ST_WADDR;
							dc_d = 2'h0;
						end else if (dc_q != 2'h0) begin
							st_d = ST_DUMMY;
						end else begin
							st_d = ST_IDLE;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						bit_d = bit_q + 4'h0001;
						if (bit_q == BIT_LAST) begin
							sda_oe_n_d = 1'b1;
							st_d = ST_MACK;
						end else begin
							sh_d = {sh_q[6:0], 1'b1};
							sda_oe_n_d = sh_q[6];
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						ack_d = !sda_s;
					end else if (scl_fall) begin
						bit_d = '0;
						if (q_cmd_q) begin
							dc_d = dc_q - 2'h1;
							st_d = (dc_q == 2'h1) ? ST_IDLE : ST_TX;
							sh_d = 8'h00FF;
						end else if (ack_q && fifo_out_valid) begin
							st_d = ST_TX;
							sh_d = fifo_out_data;
							sda_oe_n_d = fifo_out_data[7];
							fifo_pop = 1'b1;
						end else begin
							st_d = ST_IDLE;
						end
					end
				end
				default: begin
					st_d = ST_IDLE;
				end
			endcase
		end
		// Prefetch only after a read address byte matched; stalls when full
		if (kind_d == K_READ && st_d != ST_IDLE && st_d != ST_CTRL && fifo_in_ready
			&& !fifo_flush && !bus_rst_s) begin
			fifo_in_valid = 1'b1;
			addr_d = next_addr(addr_q);
		end
	end

	// Count of fetched but unsent bytes, for rollback
	logic [3:0] pend_q, pend_d;

	always_comb begin
		pend_d = pend_q;
		if (fifo_flush) begin
			pend_d = '0;
		end else begin
			pend_d = pend_q + 4'(fifo_in_valid) - 4'(fifo_pop);
		end
	end

	logic [7:0] addr_fix;

	always_comb begin
		addr_fix = addr_d;
		if (fifo_flush && kind_q == K_READ) begin
			addr_fix = addr_q - 8'(pend_q);
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q <= ST_IDLE;
			kind_q <= K_NONE;
			sh_q <= '0;
			bit_q <= '0;
			addr_q <= '0;
			half_q <= HALF_RESET;
			ack_q <= 1'b0;
			q_cmd_q <= 1'b0;
			dc_q <= '0;
			sda_oe_n_q <= 1'b1;
			pend_q <= '0;
		end else begin
			st_q <= st_d;
			kind_q <= kind_d;
			sh_q <= sh_d;
			bit_q <= bit_d;
			addr_q <= addr_fix;
			half_q <= half_d;
			ack_q <= ack_d;
			q_cmd_q <= q_cmd_d;
			dc_q <= dc_d;
			sda_oe_n_q <= sda_oe_n_d;
			pend_q <= pend_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	logic busy_q;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= (st_d != ST_IDLE);
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe_n_o = sda_oe_n_q;
	assign half_sel_o = half_q;
	assign busy_o = busy_q;
endmodule : eeprom_half_select_and_read
`default_nettype wire

// *** tb/eeprom_rd_sva.sv ***
// Pin-level assertions for the EEPROM read slave
`timescale 1ns/10ps
`default_nettype none
module eeprom_rd_sva (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// Watched pins
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_n_o,
	input wire logic bus_sw_reset_i,
	input wire logic half_sel_o,
	input wire logic busy_o
);
	// ----
	// Bus conditions
	// ----
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	sequence bus_start;
		scl_i && $fell(sda_i);
	endsequence
	sequence bus_stop;
		scl_i && $rose(sda_i);
	endsequence
	chk_open_drain: assert property (sda_o == 1'b0)
		else $error("sda_o not held low");
	chk_drive_low_scl: assert property ($changed(sda_oe_n_o) |-> !$past(scl_i, 2))
		else $error("data changed while clock high");
	chk_hold_high: assert property ($rose(scl_i) |-> ##1 $stable(sda_oe_n_o)[*2])
		else $error("data moved during clock high");
	chk_start_busy: assert property (bus_start |-> ##[1:6] busy_o)
		else $error("start not taken");
	chk_stop_idle: assert property (bus_stop |-> ##[1:8] !busy_o)
		else $error("stop did not end transfer");
	chk_idle_float: assert property (!busy_o |-> sda_oe_n_o)
		else $error("data driven while idle");
	chk_swrst_half: assert property ($rose(bus_sw_reset_i) |-> ##[1:6] !half_sel_o)
		else $error("half bit not cleared");
	chk_half_cause: assert property ($changed(half_sel_o) |->
		$past(busy_o) || $past(busy_o, 3) || bus_sw_reset_i)
		else $error("half bit moved without command");
endmodule : eeprom_rd_sva
bind eeprom_half_select_and_read eeprom_rd_sva u_sva (.clk_sys_i, .nrst_i, .scl_i,
	.sda_i, .sda_o, .sda_oe_n_o, .bus_sw_reset_i, .half_sel_o, .busy_o);
`default_nettype wire

// *** tb/bus_master_model.sv ***
// Behavioural two-wire bus master
`timescale 1ns/10ps
`default_nettype none
module bus_master_model (
	// Bus lines, 1 = released
	output logic scl_o,
	output logic sda_o,
	input wire logic sda_i
);
	// ----
	// Bit and byte cycles
	// ----
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// Long low phase lets the slave settle its sampled delay
	task automatic clk_bit(input logic b, output logic r);
		#50 sda_o = b;
		#100 scl_o = 1'b1;
		#25 r = sda_i;
		#25 scl_o = 1'b0;
	endtask : clk_bit
	task automatic start();
		sda_o = 1'b1;
		#150 scl_o = 1'b1;
		#50 sda_o = 1'b0;
		#50 scl_o = 1'b0;
	endtask : start
	task automatic stop();
		#50 sda_o = 1'b0;
		#100 scl_o = 1'b1;
		#50 sda_o = 1'b1;
		#100;
	endtask : stop
	task automatic put(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) clk_bit(b[i], r);
		clk_bit(1'b1, r);
		ack = ~r;
	endtask : put
	task automatic get(input logic ack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, r);
			b[i] = r;
		end
		clk_bit(~ack, r);
	endtask : get
endmodule : bus_master_model
`default_nettype wire

// *** tb/tb.sv ***
// Testbench for the EEPROM half select and read slave
`timescale 1ns/10ps
`default_nettype none
module tb;
	import eeprom_rd_pkg::*;
	logic clk = 1'b0;
	logic nrst_n;
	logic bus_rst;
	logic mem_we;
	logic [8:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic [2:0] strap;
	logic ack;
	logic [7:0] d;
	wire logic scl;
	wire logic m_sda;
	wire logic sda_o;
	wire logic oe_n;
	wire logic half_sel;
	wire logic busy;
	wire logic sda = m_sda & (oe_n | sda_o);
	int mismatches = 0;
	int compares = 0;
	always #12.5 clk = ~clk;
	eeprom_half_select_and_read dut (.clk_sys_i(clk), .nrst_i(nrst_n), .scl_i(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(oe_n), .strap_addr_bit0_i(strap[0]),
		.strap_addr_bit1_i(strap[1]), .strap_addr_bit2_i(strap[2]),
		.bus_sw_reset_i(bus_rst), .mem_we_i(mem_we), .mem_waddr_i(mem_waddr),
		.mem_wdata_i(mem_wdata), .half_sel_o(half_sel), .busy_o(busy));
	bus_master_model u_mst (.scl_o(scl), .sda_o(m_sda), .sda_i(sda));
	// ----
	// Helpers
	// ----
	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : cycles
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	function automatic logic [7:0] pat(input logic [8:0] a);
		return a[7:0] ^ (a[8] ? 8'hA5 : 8'h3C);
	endfunction : pat
	task automatic results();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : results
	task automatic query(input logic exp);
		u_mst.start();
		u_mst.put(CMD_HALF_QUERY, ack);
		check("query ack", 8'(ack), 8'(exp));
		repeat (2) u_mst.get(1'b0, d);
		u_mst.stop();
	endtask : query
	task automatic rd_addr(input logic [2:0] s);
		u_mst.start();
		u_mst.put({DEV_TYPE_CODE, s, 1'b1}, ack);
	endtask : rd_addr
	// ----
	// Scenarios
	// ----
	task automatic t_select();
		check("half at reset", 8'(half_sel), 8'h00);
		for (int h = 0; h < 2; h++) begin
			u_mst.start();
			u_mst.put(h ? CMD_HALF_UPPER : CMD_HALF_LOWER, ack);
			check("select ack", 8'(ack), 8'h01);
			repeat (2) begin
				u_mst.put(8'h5A, ack);
				check("filler ack", 8'(ack), 8'h01);
			end
			u_mst.stop();
			check("half bit", 8'(half_sel), 8'(h));
			query(h == 0);
		end
		$display("done select");
	endtask : t_select
	task automatic t_random();
		u_mst.start();
		u_mst.put({DEV_TYPE_CODE, strap, 1'b0}, ack);
		check("dummy ack", 8'(ack), 8'h01);
		u_mst.put(8'hF9, ack);
		check("word ack", 8'(ack), 8'h01);
		rd_addr(strap);
		check("read ack", 8'(ack), 8'h01);
		for (int i = 0; i < 10; i++) begin
			u_mst.get(i < 9, d);
			check("seq data", d, pat({1'b1, 8'(8'hF9 + i)}));
		end
		u_mst.stop();
		$display("done random");
	endtask : t_random
	task automatic t_current();
		rd_addr(strap);
		check("cur ack", 8'(ack), 8'h01);
		u_mst.get(1'b0, d);
		check("cur data", d, pat(9'h103));
		u_mst.stop();
		rd_addr(strap ^ 3'b001);
		check("strap miss", 8'(ack), 8'h00);
		u_mst.stop();
		rd_addr(strap);
		u_mst.get(1'b0, d);
		check("kept counter", d, pat(9'h104));
		u_mst.stop();
		$display("done current");
	endtask : t_current
	task automatic t_reset();
		bus_rst = 1'b1;
		cycles(10);
		bus_rst = 1'b0;
		cycles(2);
		check("half cleared", 8'(half_sel), 8'h00);
		query(1'b1);
		rd_addr(strap);
		u_mst.get(1'b0, d);
		check("lower after reset", d, pat(9'h005));
		u_mst.stop();
		$display("done reset");
	endtask : t_reset
	initial begin
		#500000;
		mismatches++;
		results();
	end
	initial begin
		nrst_n = 1'b0;
		bus_rst = 1'b0;
		mem_we = 1'b0;
		mem_waddr = 9'h000;
		mem_wdata = 8'h00;
		strap = 3'b101;
		cycles(12);
		nrst_n = 1'b1;
		for (int a = 0; a < 512; a++) begin
			mem_we = 1'b1;
			mem_waddr = 9'(a);
			mem_wdata = pat(9'(a));
			cycles(1);
		end
		mem_we = 1'b0;
		cycles(4);
		t_select();
		t_random();
		t_current();
		t_reset();
		results();
	end
endmodule : tb
`default_nettype wire
